/* logic/rsf_consts.svh */
// constants of the spi slave, data queue and pattern detector
// assumes inclusion by the interface, the design modules and the checker
//
// What this block does
// - slave-only spi link, clock idle low, data sampled on leading edge.
// - master changes mosi on falling sck, device samples on rising sck.
// - miso moves on falling sck while selected, released while nss high.
// - first byte is write bit then 7-bit address, all bytes msb first.
// - non-queue address advances after every data byte of a frame.
// - queue address stays fixed, every data byte goes to or from queue.
// - nss low opens a frame, first byte always an address byte.
// - during writes miso returns the register value before the write.
// - one queue of 66 bytes, shared by transmit and receive.
// - serializer sends bytes msb first, packs received bits into bytes.
// - not-empty flag shows stored bytes, refreshed while nss high and on its falling edge.
// - full flag high exactly when all queue entries hold data.
// - write to full queue sets overrun, drops byte; clearing empties queue.
// - frame sent flag rises when the serializer's last bit is out.
// - level flag re-evaluated only on queue reads, writes or clears.
// - queue emptied or kept on mode changes per the transition table.
// - enabled detector shifts received bits and compares with pattern.
// - first received bit meets pattern bit 7 of first byte.
// - pattern 1 to 8 bytes, up to 7 bit errors, also sent in transmit.
// - match flag cleared on leaving receive or when queue empties.
`ifndef RSF_CONSTS_SVH
`define RSF_CONSTS_SVH

`define RSF_QUEUE_DEPTH 66
`define RSF_QUEUE_ADDR  7'h00
`define RSF_ADDR_W      7
`define RSF_CNT_W       7
`define RSF_PAT_W       64

`endif

/* logic/rsf_pkg.sv */
// types shared by the spi slave, its checker and the bench
// assumes rsf_consts.svh on the include path
package rsf_pkg;

    // ==========================================================
    // operating modes and controller states
    typedef enum logic [2:0] {
        RSF_SLEEP = 3'h0,
        RSF_STDBY = 3'h1,
        RSF_FS    = 3'h2,
        RSF_TX    = 3'h3,
        RSF_RX    = 3'h4
    } rsf_mode_t;

    typedef enum logic [1:0] {
        SPI_IDLE = 2'h0,
        SPI_ADDR = 2'h1,
        SPI_DATA = 2'h3
    } rsf_spi_st_t;

    typedef enum logic [1:0] {
        SER_IDLE = 2'h0,
        SER_SYNC = 2'h1,
        SER_PAY  = 2'h3,
        SER_DONE = 2'h2
    } rsf_ser_st_t;

endpackage

/* logic/rsf_queue_if.sv */
// carrier between the spi slave and its byte queue
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "rsf_consts.svh"

interface rsf_queue_if #(parameter int DEPTH = `RSF_QUEUE_DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic          push;
    logic [7:0]    push_data;
    logic          pop;
    logic          flush;
    logic [7:0]    head;
    logic [CW-1:0] count;
    logic          empty;
    logic          full;

    modport user  (output push, push_data, pop, flush,
                   input  head, count, empty, full);
    modport store (input  push, push_data, pop, flush,
                   output head, count, empty, full);
endinterface

`default_nettype wire

/* logic/rsf_queue.sv */
// byte queue shared by transmit and receive
// assumes one push and one pop per cycle at most
`timescale 1ns/1ps
`default_nettype none
`include "rsf_consts.svh"

module rsf_queue #(
    parameter int DEPTH = `RSF_QUEUE_DEPTH
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    rsf_queue_if.store qif
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] cnt;
    } rsf_qstate_t;

    rsf_qstate_t q;
    rsf_qstate_t d;
    logic [7:0]  mem [DEPTH];
    logic        do_push;
    logic        do_pop;

    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // ==========================================================
    // pointers and count
    always_comb begin
        d       = q;
        do_push = qif.push & (q.cnt != CW'(DEPTH));
        do_pop  = qif.pop & (q.cnt != '0);
        if (do_push) begin
            d.wr = nxt(q.wr);
        end
        if (do_pop) begin
            d.rd = nxt(q.rd);
        end
        d.cnt = q.cnt + CW'(do_push) - CW'(do_pop);
        if (qif.flush) begin
            d = '0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (do_push && !qif.flush) begin
            mem[q.wr] <= qif.push_data;
        end
    end

    assign qif.head  = mem[q.rd];
    assign qif.count = q.cnt;
    assign qif.empty = (q.cnt == '0);
    assign qif.full  = (q.cnt == CW'(DEPTH));

endmodule

`default_nettype wire

/* logic/rsf_spi_slave.sv */
// spi slave register port with byte queue, serializer
// and incoming pattern detector
// assumes sck at most a quarter of i_ref_clk, i_bit_tick
// and i_rx_data generated on i_ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "rsf_consts.svh"

module rsf_spi_slave #(
    parameter int DEPTH = `RSF_QUEUE_DEPTH
) (
    input  wire logic              i_ref_clk,
    input  wire logic              i_rstn,
    input  wire logic              i_spi_sck,
    input  wire logic              i_spi_nss_n,
    input  wire logic              i_spi_mosi,
    output logic                   o_spi_miso,
    output logic                   o_spi_miso_oe,
    input  wire rsf_pkg::rsf_mode_t i_mode,
    input  wire logic [6:0]        i_queue_level_threshold,
    input  wire logic              i_queue_overrun_clear,
    input  wire logic              i_pattern_detect_enable,
    input  wire logic [2:0]        i_pattern_length,
    input  wire logic [2:0]        i_pattern_error_tolerance,
    input  wire logic [63:0]       i_pattern_value,
    input  wire logic              i_bit_tick,
    input  wire logic              i_rx_data,
    output logic                   o_tx_data,
    output logic                   o_queue_has_data_flag,
    output logic                   o_queue_full_flag,
    output logic                   o_queue_overrun_flag,
    output logic                   o_queue_level_flag,
    output logic                   o_frame_transmitted_flag,
    output logic                   o_mode_settled_flag,
    output logic                   o_pattern_match_flag
);
    import rsf_pkg::*;

    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic        sck_s1;
        logic        sck_s2;
        logic        sck_s3;
        logic        sel_s1;
        logic        sel_s2;
        logic        sel_s3;
        logic        mosi_s1;
        logic        mosi_s2;
        rsf_spi_st_t spi_st;
        logic [2:0]  bit_cnt;
        logic [7:0]  rx_sr;
        logic [7:0]  tx_sr;
        logic [6:0]  addr;
        logic        wnr;
        logic        miso;
        logic        miso_oe;
        rsf_mode_t   mode_prev;
        logic        settle_wait;
        logic        settled;
        logic        has_data;
        logic        full;
        logic        level;
        logic        qact;
        logic        overrun;
        logic        sent;
        logic        empty_q;
        rsf_ser_st_t ser_st;
        logic [2:0]  ser_cnt;
        logic [2:0]  ser_byte;
        logic [7:0]  ser_sr;
        logic        tx_data;
        logic [63:0] hist;
        logic        match;
    } rsf_state_t;

    rsf_state_t q;
    rsf_state_t d;

    logic [7:0] regs [1:127];
    logic       reg_we;
    logic [6:0] reg_wa;
    logic [7:0] reg_wd;
    logic       sck_rise;
    logic       sck_fall;
    logic       sel_rise;
    logic [7:0] in_byte;
    logic [6:0] nxt_addr;
    logic       nxt_wnr;
    logic       host_push;
    logic       ser_push;
    logic [7:0] ser_byte_in;
    logic       flush_mode;
    logic [63:0] hist_nxt;

    rsf_queue_if #(.DEPTH(DEPTH)) qif ();

    rsf_queue #(.DEPTH(DEPTH)) u_queue (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .qif       (qif)
    );

    // ==========================================================
    // helpers
    function automatic logic [7:0] reg_rd(input logic [6:0] a,
                                          input logic [7:0] h);
        if (a == `RSF_QUEUE_ADDR) begin
            reg_rd = h;
        end else begin
            reg_rd = regs[a];
        end
    endfunction

    function automatic logic [7:0] pat_byte(input logic [63:0] v,
                                            input logic [2:0]  i);
        pat_byte = v[8*(7-int'(i)) +: 8];
    endfunction

    // bit errors of the newest len bytes against the pattern
    function automatic logic [6:0] pat_errs(input logic [63:0] h,
                                            input logic [63:0] p,
                                            input logic [2:0]  lm1);
        logic [6:0] e;
        int         n;
        e = '0;
        n = 8 * (int'(lm1) + 1);
        for (int i = 0; i < 64; i++) begin
            if (i < n && h[i] != p[64 - n + i]) begin
                e = e + 7'h01;
            end
        end
        pat_errs = e;
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        d = q;
        reg_we = 1'b0;
        reg_wa = '0;
        reg_wd = '0;
        host_push = 1'b0;
        ser_push = 1'b0;
        ser_byte_in = '0;
        qif.pop = 1'b0;
        nxt_addr = q.addr;
        nxt_wnr = q.wnr;
        hist_nxt = q.hist;

        // two-flop synchronisers on the pins
        d.sck_s1 = i_spi_sck;
        d.sck_s2 = q.sck_s1;
        d.sck_s3 = q.sck_s2;
        d.sel_s1 = ~i_spi_nss_n;
        d.sel_s2 = q.sel_s1;
        d.sel_s3 = q.sel_s2;
        d.mosi_s1 = i_spi_mosi;
        d.mosi_s2 = q.mosi_s1;
        sck_rise = q.sck_s2 & ~q.sck_s3;
        sck_fall = ~q.sck_s2 & q.sck_s3;
        sel_rise = q.sel_s2 & ~q.sel_s3;
        in_byte = {q.rx_sr[6:0], q.mosi_s2};

        // spi frame handling
        if (!q.sel_s2) begin
            d.spi_st = SPI_IDLE;
            d.miso_oe = 1'b0;
            d.miso = 1'b0;
        end else begin
            if (sel_rise) begin
                d.spi_st = SPI_ADDR;
                d.bit_cnt = '0;
                d.miso_oe = 1'b1;
                d.tx_sr = '0;
            end else if (sck_rise && q.spi_st != SPI_IDLE) begin
                d.rx_sr = in_byte;
                d.bit_cnt = q.bit_cnt + 3'h1;
                // queue byte leaves once its first bit was taken
                if (q.spi_st == SPI_DATA && q.bit_cnt == 3'h0
                    && !q.wnr && q.addr == `RSF_QUEUE_ADDR) begin
                    qif.pop = 1'b1;
                end
                if (q.bit_cnt == 3'h7) begin
                    if (q.spi_st == SPI_ADDR) begin
                        nxt_wnr = q.rx_sr[6];
                        nxt_addr = {q.rx_sr[5:0], q.mosi_s2};
                        d.spi_st = SPI_DATA;
                    end else begin
                        if (q.wnr && q.addr == `RSF_QUEUE_ADDR) begin
                            host_push = 1'b1;
                        end else if (q.wnr) begin
                            reg_we = 1'b1;
                            reg_wa = q.addr;
                            reg_wd = in_byte;
                        end
                        if (q.addr != `RSF_QUEUE_ADDR) begin
                            nxt_addr = q.addr + 7'h01;
                        end
                    end
                    d.wnr = nxt_wnr;
                    d.addr = nxt_addr;
                    // old contents go out, also for writes
                    d.tx_sr = reg_rd(nxt_addr, qif.head);
                    if (reg_we && reg_wa == nxt_addr) begin
                        d.tx_sr = reg_wd;
                    end
                end
            end else if (sck_fall && q.spi_st == SPI_DATA) begin
                d.miso = q.tx_sr[7];
                d.tx_sr = {q.tx_sr[6:0], 1'b0};
            end
        end

        // serializer and pattern detector
        flush_mode = 1'b0;
        if (i_mode != q.mode_prev) begin
            flush_mode = ((q.mode_prev == RSF_STDBY
                           || q.mode_prev == RSF_SLEEP)
                          && i_mode == RSF_RX)
                       || (q.mode_prev == RSF_RX && i_mode == RSF_TX)
                       || q.mode_prev == RSF_TX;
            d.ser_st = SER_IDLE;
            d.ser_cnt = '0;
            d.sent = 1'b0;
            d.settle_wait = (q.mode_prev == RSF_TX);
        end else if (i_bit_tick && i_mode == RSF_TX) begin
            case (q.ser_st)
                SER_IDLE: begin
                    d.ser_cnt = '0;
                    d.ser_byte = '0;
                    if (i_pattern_detect_enable) begin
                        d.ser_st = SER_SYNC;
                        d.ser_sr = pat_byte(i_pattern_value, 3'h0);
                    end else if (!qif.empty) begin
                        d.ser_st = SER_PAY;
                        d.ser_sr = qif.head;
                        qif.pop = 1'b1;
                    end
                end
                SER_SYNC, SER_PAY: begin
                    d.tx_data = q.ser_sr[7];
                    d.ser_sr = {q.ser_sr[6:0], 1'b0};
                    d.ser_cnt = q.ser_cnt + 3'h1;
                    if (q.ser_cnt == 3'h7) begin
                        if (q.ser_st == SER_SYNC
                            && q.ser_byte != i_pattern_length) begin
                            d.ser_byte = q.ser_byte + 3'h1;
                            d.ser_sr = pat_byte(i_pattern_value,
                                                q.ser_byte + 3'h1);
                        end else if (!qif.empty) begin
                            d.ser_st = SER_PAY;
                            d.ser_sr = qif.head;
                            qif.pop = 1'b1;
                        end else begin
                            d.ser_st = SER_DONE;
                            d.sent = 1'b1;
                        end
                    end
                end
                SER_DONE: begin
                    d.ser_st = SER_DONE;
                end
                default: begin
                    d.ser_st = SER_IDLE;
                end
            endcase
        end else if (i_bit_tick && i_mode == RSF_RX) begin
            hist_nxt = {q.hist[62:0], i_rx_data};
            d.hist = hist_nxt;
            if (q.match) begin
                ser_byte_in = {q.ser_sr[6:0], i_rx_data};
                d.ser_sr = ser_byte_in;
                d.ser_cnt = q.ser_cnt + 3'h1;
                ser_push = (q.ser_cnt == 3'h7);
            end
        end
        if (i_bit_tick) begin
            d.settle_wait = 1'b0;
        end
        d.mode_prev = i_mode;
        d.settled = (i_mode == q.mode_prev) && !q.settle_wait;

        // queue control, serializer push has priority
        qif.push = ser_push | host_push;
        qif.push_data = ser_push ? ser_byte_in : in_byte;
        qif.flush = flush_mode | i_queue_overrun_clear;

        // match flag, set wins over clear
        d.empty_q = qif.empty;
        if ((q.mode_prev == RSF_RX && i_mode != RSF_RX)
            || (qif.empty && !q.empty_q)) begin
            d.match = 1'b0;
        end
        if (i_bit_tick && i_mode == RSF_RX && i_mode == q.mode_prev
            && i_pattern_detect_enable && !q.match
            && pat_errs(hist_nxt, i_pattern_value, i_pattern_length)
               <= {4'h0, i_pattern_error_tolerance}) begin
            d.match = 1'b1;
            d.ser_cnt = '0;
        end

        // queue flags
        if (!q.sel_s2 || sel_rise) begin
            d.has_data = !qif.empty;
        end
        d.full = qif.full;
        d.qact = qif.push | qif.pop | qif.flush;
        if (q.qact) begin
            d.level = qif.count > CW'(i_queue_level_threshold);
        end
        if (i_queue_overrun_clear) begin
            d.overrun = 1'b0;
        end
        if (qif.push && qif.full) begin
            d.overrun = 1'b1;
        end
    end

    // ==========================================================
    // state registers
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (reg_we) begin
            regs[reg_wa] <= reg_wd;
        end
    end

    // ==========================================================
    // outputs
    assign o_spi_miso               = q.miso;
    assign o_spi_miso_oe            = q.miso_oe;
    assign o_tx_data                = q.tx_data;
    assign o_queue_has_data_flag    = q.has_data;
    assign o_queue_full_flag        = q.full;
    assign o_queue_overrun_flag     = q.overrun;
    assign o_queue_level_flag       = q.level;
    assign o_frame_transmitted_flag = q.sent;
    assign o_mode_settled_flag      = q.settled;
    assign o_pattern_match_flag     = q.match;

endmodule

`default_nettype wire

/* sim/rsf_spi_slave_asserts.sv */
// checker for the spi slave, queue flags, serializer and detector
// assumes it is bound to rsf_spi_slave and sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "rsf_consts.svh"

module rsf_spi_slave_asserts
    import rsf_pkg::*;
#(
    parameter int DEPTH = `RSF_QUEUE_DEPTH
) (
    input wire logic                i_ref_clk,
    input wire logic                i_rstn,
    input wire logic                i_spi_sck,
    input wire logic                i_spi_nss_n,
    input wire logic                o_spi_miso,
    input wire logic                o_spi_miso_oe,
    input wire rsf_pkg::rsf_mode_t  i_mode,
    input wire logic                i_queue_overrun_clear,
    input wire logic                i_pattern_detect_enable,
    input wire logic                i_bit_tick,
    input wire logic                o_tx_data,
    input wire logic                o_queue_full_flag,
    input wire logic                o_queue_overrun_flag,
    input wire logic                o_frame_transmitted_flag,
    input wire logic                o_mode_settled_flag,
    input wire logic                o_pattern_match_flag
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    // ==========================================================
    // link framing
    sequence s_frame_open;
        $fell(i_spi_nss_n) ##1 (!i_spi_nss_n) [*6];
    endsequence
    sequence s_sck_high;
        i_spi_sck [*3];
    endsequence

    a_oe_opens: assert property (s_frame_open |-> o_spi_miso_oe)
        else $error("miso not driven in open frame");
    a_oe_release: assert property (
        i_spi_nss_n [*8] |-> !o_spi_miso_oe)
        else $error("miso driven while deselected");
    a_miso_hold_high: assert property (
        s_sck_high |-> $stable(o_spi_miso))
        else $error("miso moved while sck high");

    // ==========================================================
    // queue, serializer, detector and mode settling
    a_clear_empties: assert property (
        i_queue_overrun_clear && i_spi_nss_n
        && $past(i_spi_nss_n, 4) && i_mode == RSF_STDBY
        |-> ##3 (!o_queue_overrun_flag && !o_queue_full_flag))
        else $error("overrun clear left flags set");
    a_tx_hold: assert property (
        !$past(i_bit_tick) && i_mode == $past(i_mode, 2)
        |-> $stable(o_tx_data))
        else $error("tx bit moved without tick");
    a_sent_on_tick: assert property ($rose(o_frame_transmitted_flag)
        |-> $past(i_bit_tick) && $past(i_mode) == RSF_TX)
        else $error("frame sent rose outside a tx tick");
    a_match_on_tick: assert property ($rose(o_pattern_match_flag)
        |-> $past(i_bit_tick) && $past(i_pattern_detect_enable))
        else $error("match rose without an enabled tick");
    a_match_leave_rx: assert property ((i_mode != RSF_RX) [*3]
        |-> !o_pattern_match_flag)
        else $error("match held outside receive");
    a_settled_drops: assert property (i_mode != $past(i_mode)
        |-> ##[1:2] !o_mode_settled_flag)
        else $error("settled flag ignored a mode change");
endmodule

bind rsf_spi_slave rsf_spi_slave_asserts #(.DEPTH(DEPTH)) u_chk (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_spi_sck(i_spi_sck),
    .i_spi_nss_n(i_spi_nss_n), .o_spi_miso(o_spi_miso),
    .o_spi_miso_oe(o_spi_miso_oe), .i_mode(i_mode),
    .i_queue_overrun_clear(i_queue_overrun_clear),
    .i_pattern_detect_enable(i_pattern_detect_enable),
    .i_bit_tick(i_bit_tick), .o_tx_data(o_tx_data),
    .o_queue_full_flag(o_queue_full_flag),
    .o_queue_overrun_flag(o_queue_overrun_flag),
    .o_frame_transmitted_flag(o_frame_transmitted_flag),
    .o_mode_settled_flag(o_mode_settled_flag),
    .o_pattern_match_flag(o_pattern_match_flag)
);

`default_nettype wire

/* sim/rsf_spi_master_model.sv */
// spi master model standing in for the host microcontroller
// assumes the bench fills tx_q and then calls run_frame
`timescale 1ns/1ps
`default_nettype none

module rsf_spi_master_model (
    output logic      o_sck,
    output logic      o_nss_n,
    output logic      o_mosi,
    input  wire logic i_miso,
    input  wire logic i_miso_oe
);
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];
    logic       float_n = 1'b0;
    wire        line = i_miso_oe ? i_miso : float_n;

    // released line shows the inverse of its last driven level
    always @(i_miso or i_miso_oe) begin
        if (i_miso_oe) float_n = ~i_miso;
    end

    initial begin
        o_sck   = 1'b0;
        o_nss_n = 1'b1;
        o_mosi  = 1'b0;
    end

    // ==========================================================
    // one frame: select, bytes msb first, deselect
    task automatic run_frame();
        logic [7:0] r;
        rx_q = {};
        o_nss_n = 1'b0;
        #400;
        foreach (tx_q[i]) begin
            for (int b = 7; b >= 0; b--) begin
                o_mosi = tx_q[i][b];
                #200 o_sck = 1'b1;
                #100 r[b] = line;
                #100 o_sck = 1'b0;
            end
            rx_q.push_back(r);
        end
        #200 o_nss_n = 1'b1;
        #800;
    endtask
endmodule

`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the spi slave with byte queue and detector
// assumes the master model drives the link, bench drives the rest
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import rsf_pkg::*;

    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        sck, nss_n, mosi, miso, miso_oe;
    rsf_mode_t   mode = RSF_STDBY;
    logic [6:0]  thr = 7'h03;
    logic        ovr_clr = 1'b0;
    logic        pd_en = 1'b0;
    logic [2:0]  plen = 3'h0;
    logic [2:0]  ptol = 3'h0;
    logic [63:0] pval = 64'h2dd4_1122_3344_5566;
    logic        tick = 1'b0;
    logic        rxd = 1'b0;
    logic        txd, has, full, ovr, lvl, sent, settled, match;
    int          fail_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    logic [15:0] sr;
    logic [7:0]  q[$];
    rsf_mode_t   frm[6] = '{RSF_STDBY, RSF_SLEEP, RSF_STDBY,
                            RSF_RX, RSF_TX, RSF_RX};
    rsf_mode_t   dst[6] = '{RSF_SLEEP, RSF_TX, RSF_RX,
                            RSF_TX, RSF_STDBY, RSF_STDBY};
    logic        keep[6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};

    rsf_spi_master_model host (
        .o_sck(sck), .o_nss_n(nss_n), .o_mosi(mosi),
        .i_miso(miso), .i_miso_oe(miso_oe)
    );
    rsf_spi_slave dut (
        .i_ref_clk(clk), .i_rstn(rstn), .i_spi_sck(sck),
        .i_spi_nss_n(nss_n), .i_spi_mosi(mosi), .o_spi_miso(miso),
        .o_spi_miso_oe(miso_oe), .i_mode(mode),
        .i_queue_level_threshold(thr), .i_queue_overrun_clear(ovr_clr),
        .i_pattern_detect_enable(pd_en), .i_pattern_length(plen),
        .i_pattern_error_tolerance(ptol), .i_pattern_value(pval),
        .i_bit_tick(tick), .i_rx_data(rxd), .o_tx_data(txd),
        .o_queue_has_data_flag(has), .o_queue_full_flag(full),
        .o_queue_overrun_flag(ovr), .o_queue_level_flag(lvl),
        .o_frame_transmitted_flag(sent), .o_mode_settled_flag(settled),
        .o_pattern_match_flag(match)
    );

    initial forever #25 clk = ~clk;

    // ==========================================================
    // helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL at %0t ns: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic xfer(input logic [7:0] a, input logic [7:0] d[$]);
        host.tx_q = d;
        host.tx_q.push_front(a);
        host.run_frame();
    endtask
    task automatic clear_queue();
        ovr_clr = 1'b1;
        cycles(1);
        ovr_clr = 1'b0;
        cycles(4);
    endtask
    task automatic tick_once(input logic d);
        @(posedge clk);
        #5 rxd = d;
        tick = 1'b1;
        @(posedge clk);
        #5 tick = 1'b0;
    endtask
    task automatic feed(input logic [15:0] w, input int n);
        for (int b = 15; b > 15 - n; b--) tick_once(w[b]);
    endtask
    task automatic set_mode(input rsf_mode_t md);
        mode = md;
        cycles(3);
        if (md != RSF_TX) tick_once(1'b0);
        for (int i = 0; i < 40 && settled !== 1'b1; i++) cycles(1);
        check(settled, 1'b1);
    endtask
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            wrap_up();
        end
    end

    // ==========================================================
    // tests
    initial begin
        repeat (3) @(posedge clk);
        #5 rstn = 1'b1;
        cycles(4);
        xfer(8'h85, '{8'h11, 8'h22, 8'h33});
        xfer(8'h85, '{8'ha1, 8'ha2});
        check(host.rx_q[1], 8'h11);
        check(host.rx_q[2], 8'h22);
        xfer(8'h05, '{8'h00, 8'h00, 8'h00});
        check(host.rx_q[1], 8'ha1);
        check(host.rx_q[2], 8'ha2);
        check(host.rx_q[3], 8'h33);
        $display("register test over");
        for (int i = 1; i <= 67; i++) q.push_back(8'(i));
        xfer(8'h80, q);
        check(full, 1'b1);
        check(ovr, 1'b1);
        check(lvl, 1'b1);
        for (int i = 1; i <= 66; i++) begin
            check(has, 1'b1);
            xfer(8'h00, '{8'h00});
            check(host.rx_q[1], 8'(i));
            if (i == 1) check(full, 1'b0);
        end
        check(has, 1'b0);
        xfer(8'h80, '{8'haa, 8'hbb});
        clear_queue();
        check(ovr, 1'b0);
        check(has, 1'b0);
        xfer(8'h80, '{8'h01, 8'h02, 8'h03, 8'h04});
        check(lvl, 1'b1);
        thr = 7'h0a;
        cycles(4);
        check(lvl, 1'b1);
        xfer(8'h00, '{8'h00});
        check(lvl, 1'b0);
        $display("queue test over");
        for (int i = 0; i < 6; i++) begin
            set_mode(frm[i]);
            clear_queue();
            xfer(8'h80, '{8'h5a});
            set_mode(dst[i]);
            check(has, keep[i]);
        end
        $display("mode test over");
        clear_queue();
        xfer(8'h80, '{8'ha5});
        pd_en = 1'b1;
        set_mode(RSF_TX);
        sr = 16'h0000;
        for (int i = 0; i < 40 && sent !== 1'b1; i++) begin
            tick_once(1'b0);
            sr = {sr[14:0], txd};
        end
        check(sent, 1'b1);
        check(sr, 16'h2da5);
        $display("transmit test over");
        set_mode(RSF_RX);
        plen = 3'h1;
        feed(16'h2cd4, 16);
        check(match, 1'b0);
        feed(16'h2cd4, 15);
        ptol = 3'h1;
        feed(16'h0000, 1);
        check(match, 1'b1);
        feed(16'h5a00, 8);
        cycles(4);
        check(has, 1'b1);
        xfer(8'h00, '{8'h00});
        check(host.rx_q[1], 8'h5a);
        check(match, 1'b0);
        feed(16'h2dd4, 16);
        check(match, 1'b1);
        set_mode(RSF_STDBY);
        check(match, 1'b0);
        $display("receive test over");
        wrap_up();
    end
endmodule

`default_nettype wire
